// [fpp_protect.sv]
// Flash program memory protection: reset load, write/read locks, write key, test access
// Functional notes
// - Boot control byte loads after reset; bit 7 reserved, bits 6:0 boot limit.
// - Limit not 7F blocks writes from 0 to limit*128+15.
// - Limit 7F means no boot region, no boot protection.
// - Code control word loads after reset: blank 15:13, reserved 12:10, start 9:0.
// - Blank pattern with two or more bits set and env pins high selects programming environment.
// - Start not 3FF blocks writes start*128 to 1FFF; 3FF disables it.
// - Security byte loads after reset: write lock 7:4, read lock 3:0.
// - Lock code enabled when zero or single bit set, else disabled.
// - Read lock returns zero outside normal run environment.
// - Read lock drops reserved odd-byte erases and mass erases unless overridden.
// - Write lock drops program writes, reserved odd erases, mass erases unless overridden.
// - Programming-flash write proceeds only with key 6A written just before.
// - Wrong key write clears key; repeated correct key keeps it set.
// - Key register always reads FF.
// - Test mode gives pins direct array access bypassing the core.
// - Test access reaches all cells not dropped by an enabled lock, including data-unused bytes.
// - Protection values change only at the next reset reload.
// - Enabled locks cannot be disabled by any path.
// - Control bytes copied before the first instruction fetch.
//
// The address-and-strobe port and the address map were left to the implementer.
`include "fpp_protect_params.svh"
`timescale 1ns/10ps
`default_nettype none
module fpp_protect #(
    parameter int ENV_W = 2
) (
    input  wire logic                     clock,
    input  wire logic                     rstn,
    input  wire logic [7:0]               regAddr,
    input  wire logic [15:0]              regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic      [15:0]              regRdata,
    input  wire logic [ENV_W-1:0]         envSelPins,
    input  wire logic                     testMode,
    input  wire logic                     securityOverridePin,
    input  wire fpp_protect_pkg::fpp_req_s cpuReq,
    input  wire fpp_protect_pkg::fpp_req_s testReq,
    input  wire logic                     cpuRdReq,
    input  wire logic [15:0]              cpuRdAddr,
    input  wire logic [15:0]              arrRdData,
    output logic                          arrRdEn,
    output logic      [15:0]              arrRdAddr,
    output logic      [15:0]              cpuRdData,
    output logic                          cpuRdValid,
    output fpp_protect_pkg::fpp_req_s     flashCmd,
    output logic                          loadDone,
    output logic                          inSystemProgEnv,
    output logic                          normalRunEnv
);
    fpp_protect_pkg::fpp_state_e state_reg;
    fpp_protect_pkg::fpp_req_s   req;
    logic [7:0]  bootCtrl_reg;
    logic [15:0] codeCtrl_reg;
    logic [7:0]  secCtrl_reg;
    logic        key_reg;
    logic        capValid_reg;
    logic [1:0]  capIdx_reg;
    logic        rdGate_reg;
    logic        rdPend_reg;
    logic        running;
    logic        readLock;
    logic        writeLock;
    logic        inBoot;
    logic        inCode;
    logic        inIsp;
    logic        inPgm;
    logic        rsvOdd;
    logic        allow;
    logic        keyWr;
    logic        keyGood;
    logic [16:0] codeLo;

    // Lock code: zero or a single set bit
    function automatic logic lockOn(input logic [3:0] code);
        lockOn = ($countones(code) <= 1);
    endfunction

    assign running  = (state_reg == fpp_protect_pkg::S_RUN);
    assign readLock  = lockOn(secCtrl_reg[`FPP_RLOCK_MSB:0]);
    assign writeLock = lockOn(secCtrl_reg[`FPP_WLOCK_MSB:`FPP_WLOCK_LSB]);
    assign req      = testMode ? testReq : cpuReq;
    assign keyWr    = regWr && (regAddr == `FPP_OFS_KEY);
    assign keyGood  = keyWr && (regWdata[7:0] == `FPP_KEY_VALUE);
    assign codeLo   = {codeCtrl_reg[`FPP_CODE_MSB:0], 7'h00};

    // boot region decode, limit 7F disables
    assign inBoot = (bootCtrl_reg[6:0] != `FPP_BOOT_OFF) &&
                    (req.addr[15:7] <= {2'h0, bootCtrl_reg[6:0]}) &&
                    ((req.addr[15:7] < {2'h0, bootCtrl_reg[6:0]}) || (req.addr[6:0] <= `FPP_BOOT_TAIL));
    assign inCode = (codeCtrl_reg[`FPP_CODE_MSB:0] != `FPP_CODE_OFF) &&
                    ({1'b0, req.addr} >= codeLo) && ({1'b0, req.addr} <= `FPP_ADR_CODE_END);
    assign inIsp  = (req.addr >= `FPP_ADR_ISP_LO) && (req.addr <= `FPP_ADR_ISP_HI);
    assign inPgm  = (req.addr < `FPP_ADR_PGM_END);
    assign rsvOdd = (req.addr >= `FPP_ADR_RSV_LO) && (req.addr <= `FPP_ADR_ISP_HI) && req.addr[0];

    // Decide whether a request reaches the array
    always_comb begin
        allow = req.valid && running;
        // test pins bypass region and key checks
        // array cells outside enabled locks reachable in test mode
        if (!testMode) begin
            if (req.op != fpp_protect_pkg::OP_MASS && inPgm && (inBoot || inCode)) begin
                allow = 1'b0;
            end
            if (req.op != fpp_protect_pkg::OP_MASS && inIsp && !key_reg) begin
                allow = 1'b0;
            end
        end
        if (!securityOverridePin) begin
            // read lock guards odd reserved-byte erases and mass erase
            if (readLock && (req.op == fpp_protect_pkg::OP_MASS ||
                             (req.op == fpp_protect_pkg::OP_ERASE && rsvOdd))) begin
                allow = 1'b0;
            end
            // write lock guards program-area commands, mass erase and odd reserved erases
            if (writeLock && (inPgm || req.op == fpp_protect_pkg::OP_MASS ||
                              (req.op == fpp_protect_pkg::OP_ERASE && rsvOdd))) begin
                allow = 1'b0;
            end
        end
    end

    // load sequence before the core may fetch
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= fpp_protect_pkg::S_FC;
        end else begin
            case (state_reg)
                fpp_protect_pkg::S_FC:    state_reg <= fpp_protect_pkg::S_FD;
                fpp_protect_pkg::S_FD:    state_reg <= fpp_protect_pkg::S_FE;
                fpp_protect_pkg::S_FE:    state_reg <= fpp_protect_pkg::S_FF;
                fpp_protect_pkg::S_FF:    state_reg <= fpp_protect_pkg::S_DRAIN;
                fpp_protect_pkg::S_DRAIN: begin
                    if (capValid_reg && capIdx_reg == 2'h3) begin
                        state_reg <= fpp_protect_pkg::S_RUN;
                    end
                end
                fpp_protect_pkg::S_RUN:   state_reg <= fpp_protect_pkg::S_RUN;
                default:                  state_reg <= fpp_protect_pkg::S_FC;
            endcase
        end
    end

    // Array read port shared by loader and core
    always_ff @(posedge clock) begin
        if (!rstn) begin
            arrRdEn   <= 1'b0;
            arrRdAddr <= 16'h0000;
        end else begin
            case (state_reg)
                fpp_protect_pkg::S_FC: begin
                    arrRdEn   <= 1'b1;
                    arrRdAddr <= `FPP_ADR_CODE_LO;
                end
                fpp_protect_pkg::S_FD: begin
                    arrRdEn   <= 1'b1;
                    arrRdAddr <= `FPP_ADR_BOOT;
                end
                fpp_protect_pkg::S_FE: begin
                    arrRdEn   <= 1'b1;
                    arrRdAddr <= `FPP_ADR_CODE_HI;
                end
                fpp_protect_pkg::S_FF: begin
                    arrRdEn   <= 1'b1;
                    arrRdAddr <= `FPP_ADR_SEC;
                end
                fpp_protect_pkg::S_RUN: begin
                    arrRdEn   <= cpuRdReq;
                    arrRdAddr <= cpuRdAddr;
                end
                default: begin
                    arrRdEn   <= 1'b0;
                    arrRdAddr <= 16'h0000;
                end
            endcase
        end
    end

    // Track which reserved byte returns next
    always_ff @(posedge clock) begin
        if (!rstn) begin
            capValid_reg <= 1'b0;
            capIdx_reg   <= 2'h0;
        end else begin
            capValid_reg <= arrRdEn && !running;
            capIdx_reg   <= arrRdAddr[1:0];
        end
    end

    // loaded only during the reset sequence
    // no software path alters the locks
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bootCtrl_reg <= `FPP_RST_BOOT;
            codeCtrl_reg <= `FPP_RST_CODE;
            secCtrl_reg  <= `FPP_RST_SEC;
        end else if (capValid_reg && !running) begin
            case (capIdx_reg)
                2'h0: codeCtrl_reg[7:0] <= arrRdData[7:0];
                2'h1: bootCtrl_reg      <= {1'b0, arrRdData[6:0]};
                2'h2: codeCtrl_reg[15:8] <= {arrRdData[7:5], 3'h0, arrRdData[1:0]};
                2'h3: secCtrl_reg       <= arrRdData[7:0];
                default: secCtrl_reg    <= secCtrl_reg;
            endcase
        end
    end

    // environment chosen as the load finishes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            inSystemProgEnv <= 1'b0;
            normalRunEnv    <= 1'b0;
            loadDone        <= 1'b0;
        end else begin
            loadDone <= running;
            if (state_reg == fpp_protect_pkg::S_DRAIN && capValid_reg && capIdx_reg == 2'h3) begin
                inSystemProgEnv <= ($countones(codeCtrl_reg[`FPP_BLANK_MSB:`FPP_BLANK_LSB]) >= 2) &&
                                   (&envSelPins);
                normalRunEnv    <= !(($countones(codeCtrl_reg[`FPP_BLANK_MSB:`FPP_BLANK_LSB]) >= 2) &&
                                     (&envSelPins)) && !testMode;
            end else if (running) begin
                normalRunEnv <= !inSystemProgEnv && !testMode;
            end
        end
    end

    // key consumed by any other register write or by a core request outside test mode
    // correct key sets, wrong write clears
    always_ff @(posedge clock) begin
        if (!rstn) begin
            key_reg <= 1'b0;
        end else if (keyGood) begin
            key_reg <= 1'b1;
        end else if ((regWr && !keyWr) || keyWr || (cpuReq.valid && running && !testMode)) begin
            key_reg <= 1'b0;
        end
    end

    // blocked commands never reach the array
    always_ff @(posedge clock) begin
        if (!rstn) begin
            flashCmd <= '0;
        end else begin
            flashCmd       <= req;
            flashCmd.valid <= allow;
        end
    end

    // read data gated under read lock outside normal run
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdGate_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            cpuRdValid <= 1'b0;
            cpuRdData  <= 16'h0000;
        end else begin
            rdGate_reg <= readLock && !normalRunEnv;
            // Valid waits for array data
            rdPend_reg <= arrRdEn && running;
            cpuRdValid <= rdPend_reg;
            cpuRdData  <= rdGate_reg ? 16'h0000 : arrRdData;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `FPP_OFS_BOOT: regRdata <= {8'h00, bootCtrl_reg};
                `FPP_OFS_CODE: regRdata <= codeCtrl_reg;
                `FPP_OFS_SEC:  regRdata <= {8'h00, secCtrl_reg};
                `FPP_OFS_KEY:  regRdata <= `FPP_KEY_READ;
                default:       regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_boot_block;
        running && !testMode && req.valid && inBoot && req.op == fpp_protect_pkg::OP_WRITE |=> !flashCmd.valid;
    endproperty
    a_boot_block: assert property (p_boot_block) else $error("boot region write passed");
    property p_code_block;
        running && !testMode && req.valid && inCode && inPgm && req.op == fpp_protect_pkg::OP_WRITE
            |=> !flashCmd.valid;
    endproperty
    a_code_block: assert property (p_code_block) else $error("code area write passed");
    property p_isp_key;
        running && !testMode && req.valid && inIsp && !key_reg && req.op == fpp_protect_pkg::OP_WRITE
            |=> !flashCmd.valid;
    endproperty
    a_isp_key: assert property (p_isp_key) else $error("keyless flash write passed");
    property p_key_set;
        keyGood |=> key_reg;
    endproperty
    a_key_set: assert property (p_key_set) else $error("correct key not held");
    property p_key_clr;
        keyWr && !keyGood |=> !key_reg;
    endproperty
    a_key_clr: assert property (p_key_clr) else $error("wrong key left key set");
    property p_key_read;
        regRd && regAddr == `FPP_OFS_KEY |=> regRdata == `FPP_KEY_READ;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key read not FF");
    property p_wlock;
        running && writeLock && !securityOverridePin && req.valid && inPgm |=> !flashCmd.valid;
    endproperty
    a_wlock: assert property (p_wlock) else $error("write lock bypassed");
    property p_mass;
        running && readLock && !securityOverridePin && req.valid && req.op == fpp_protect_pkg::OP_MASS
            |=> !flashCmd.valid;
    endproperty
    a_mass: assert property (p_mass) else $error("mass erase under read lock");
    property p_read_zero;
        running && readLock && !normalRunEnv && $stable(normalRunEnv) && arrRdEn ##1 1'b1
            |=> cpuRdValid && cpuRdData == 16'h0000;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("locked read returned data");
    property p_stable_ctrl;
        running |=> $stable(bootCtrl_reg) && $stable(codeCtrl_reg) && $stable(secCtrl_reg);
    endproperty
    a_stable_ctrl: assert property (p_stable_ctrl) else $error("control changed after load");
    property p_load_time;
        $rose(rstn) |-> ##[1:8] running;
    endproperty
    a_load_time: assert property (p_load_time) else $error("load did not finish");
    property p_rd_valid;
        running && arrRdEn |=> ##1 cpuRdValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read answer not on time");
    property p_override;
        running && !testMode && securityOverridePin && req.valid && inPgm && !inBoot && !inCode &&
            req.op == fpp_protect_pkg::OP_WRITE |=> flashCmd.valid;
    endproperty
    a_override: assert property (p_override) else $error("override write dropped");
    property p_test_pass;
        running && testMode && req.valid && req.op == fpp_protect_pkg::OP_WRITE &&
            !(writeLock && inPgm && !securityOverridePin) |=> flashCmd.valid;
    endproperty
    a_test_pass: assert property (p_test_pass) else $error("test write dropped");
    property p_idle_load;
        !running |=> !flashCmd.valid;
    endproperty
    a_idle_load: assert property (p_idle_load) else $error("command before load done");
    c_run: cover property (running && !inSystemProgEnv);
    c_isp: cover property (running && inSystemProgEnv);
    c_keyed: cover property (keyGood ##1 req.valid && inIsp && allow);
    c_test: cover property (testMode && req.valid && allow);
endmodule
`default_nettype wire

// [fpp_protect_params.svh]
// Offsets, addresses, field positions, key values and reset values for the flash protection block
`ifndef FPP_PROTECT_PARAMS_SVH
`define FPP_PROTECT_PARAMS_SVH
`define FPP_OFS_BOOT        8'h00
`define FPP_OFS_CODE        8'h04
`define FPP_OFS_SEC         8'h08
`define FPP_OFS_KEY         8'h0C
`define FPP_ADR_CODE_LO     16'hE5FC
`define FPP_ADR_BOOT        16'hE5FD
`define FPP_ADR_CODE_HI     16'hE5FE
`define FPP_ADR_SEC         16'hE5FF
`define FPP_ADR_RSV_LO      16'hE5F9
`define FPP_ADR_ISP_LO      16'hE000
`define FPP_ADR_ISP_HI      16'hE5FF
`define FPP_ADR_PGM_END     16'hC000
`define FPP_ADR_CODE_END    17'h01FFF
`define FPP_BOOT_OFF        7'h7F
`define FPP_CODE_OFF        10'h3FF
`define FPP_BOOT_TAIL       7'h0F
`define FPP_KEY_VALUE       8'h6A
`define FPP_KEY_READ        16'h00FF
`define FPP_BLANK_MSB       15
`define FPP_BLANK_LSB       13
`define FPP_CODE_MSB        9
`define FPP_WLOCK_MSB       7
`define FPP_WLOCK_LSB       4
`define FPP_RLOCK_MSB       3
`define FPP_RST_BOOT        8'h7F
`define FPP_RST_CODE        16'h03FF
`define FPP_RST_SEC         8'h00
`endif

// [fpp_protect_pkg.sv]
// Types shared by the flash protection block
package fpp_protect_pkg;
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_ERASE = 2'h1,
        OP_MASS  = 2'h2
    } fpp_op_e;
    typedef struct packed {
        logic        valid;
        fpp_op_e     op;
        logic [15:0] addr;
        logic [15:0] data;
    } fpp_req_s;
    typedef enum logic [5:0] {
        S_FC    = 6'h01,
        S_FD    = 6'h02,
        S_FE    = 6'h04,
        S_FF    = 6'h08,
        S_DRAIN = 6'h10,
        S_RUN   = 6'h20
    } fpp_state_e;
endpackage

// [tb.sv]
// Self-checking testbench for the flash protection block
`include "fpp_protect_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {
        fpp_protect_pkg::fpp_op_e op;
        logic [15:0]              addr;
        logic                     key;
        logic                     ok;
    } fpp_row_s;
    localparam fpp_protect_pkg::fpp_op_e WR = fpp_protect_pkg::OP_WRITE;
    localparam fpp_protect_pkg::fpp_op_e ER = fpp_protect_pkg::OP_ERASE;
    localparam fpp_protect_pkg::fpp_op_e MS = fpp_protect_pkg::OP_MASS;
    // Region edges, key gating and silent drops with both locks off
    localparam fpp_row_s ROWS [11] = '{
        '{WR, 16'h008F, 1'b0, 1'b0}, '{WR, 16'h0090, 1'b0, 1'b1}, '{ER, 16'h0000, 1'b0, 1'b0},
        '{WR, 16'h17FF, 1'b0, 1'b1}, '{WR, 16'h1800, 1'b0, 1'b0}, '{WR, 16'h1FFF, 1'b0, 1'b0},
        '{WR, 16'h2000, 1'b0, 1'b1}, '{WR, 16'hE010, 1'b1, 1'b1}, '{WR, 16'hE010, 1'b0, 1'b0},
        '{MS, 16'h0000, 1'b1, 1'b1}, '{ER, 16'hE5F9, 1'b1, 1'b1}};
    localparam logic [7:0]  OFS [3] = '{`FPP_OFS_BOOT, `FPP_OFS_CODE, `FPP_OFS_SEC};
    localparam logic [15:0] PRE [3] = '{16'h007F, 16'h03FF, 16'h0000};
    logic                      clock, rstn, regWr, regRd, testMode, securityOverridePin, cpuRdReq;
    logic                      arrRdEn, cpuRdValid, loadDone, inSystemProgEnv, normalRunEnv;
    logic [7:0]                regAddr, bootByte, codeLo, codeHi, secByte;
    logic [15:0]               regWdata, regRdata, cpuRdAddr, arrRdData, arrRdAddr, cpuRdData;
    logic [1:0]                envSelPins;
    fpp_protect_pkg::fpp_req_s cpuReq, testReq, flashCmd;
    int                        errTotal, samplesChecked;

    fpp_protect #(.ENV_W(2)) i_dut (
        .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .envSelPins(envSelPins), .testMode(testMode), .cpuReq(cpuReq),
        .securityOverridePin(securityOverridePin), .testReq(testReq), .cpuRdReq(cpuRdReq),
        .cpuRdAddr(cpuRdAddr), .arrRdData(arrRdData), .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr),
        .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid), .flashCmd(flashCmd), .loadDone(loadDone),
        .inSystemProgEnv(inSystemProgEnv), .normalRunEnv(normalRunEnv));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function automatic logic [15:0] memWord(input logic [15:0] a);
        logic [7:0] b;
        case (a)
            `FPP_ADR_CODE_LO: b = codeLo;
            `FPP_ADR_BOOT:    b = bootByte;
            `FPP_ADR_CODE_HI: b = codeHi;
            `FPP_ADR_SEC:     b = secByte;
            default:          b = a[7:0] ^ a[15:8];
        endcase
        return {b, b};
    endfunction

    // Array stand-in: data one cycle after enable, toggling garbage otherwise
    always @(posedge clock) begin
        if (!rstn)
            arrRdData <= 16'h0000;
        else if (arrRdEn)
            arrRdData <= memWord(arrRdAddr);
        else
            arrRdData <= ~arrRdData;
    end

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic checkCmd(input fpp_protect_pkg::fpp_req_s exp);
        samplesChecked++;
        if (exp.valid ? (flashCmd !== exp) : (flashCmd.valid !== 1'b0)) begin
            errTotal++;
            $display("Error at %0t: command got %h expected %h", $time, flashCmd, exp);
        end
    endtask

    task automatic hangCheck(input int n, input int limit, input string what);
        if (n >= limit) begin
            errTotal++;
            $display("Error at %0t: %s never came", $time, what);
            end_of_test();
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic regRead(input logic [7:0] a, input logic [15:0] exp, input string what);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        check(regRdata, exp, what);
    endtask

    task automatic checkRegs(input logic [7:0] b, lo, hi, s);
        regRead(`FPP_OFS_BOOT, {9'h000, b[6:0]}, "boot control");
        regRead(`FPP_OFS_CODE, {hi[7:5], 3'b000, hi[1:0], lo}, "code control");
        regRead(`FPP_OFS_SEC, {8'h00, s}, "security");
    endtask

    task automatic sendReq(input logic viaTest, input fpp_protect_pkg::fpp_op_e op, input logic [15:0] a,
                           input logic key, input logic ok);
        fpp_protect_pkg::fpp_req_s r;
        r = '{1'b1, op, a, a ^ 16'h5A5A};
        if (key)
            regWrite(`FPP_OFS_KEY, 16'h006A);
        if (viaTest)
            testReq <= r;
        else
            cpuReq <= r;
        @(posedge clock);
        testReq.valid <= 1'b0;
        cpuReq.valid <= 1'b0;
        #1;
        r.valid = ok;
        checkCmd(r);
    endtask

    task automatic cpuRead(input logic [15:0] a, input logic [15:0] exp);
        int n;
        cpuRdReq <= 1'b1;
        cpuRdAddr <= a;
        @(posedge clock);
        cpuRdReq <= 1'b0;
        #1;
        n = 0;
        while (cpuRdValid !== 1'b1 && n < 6) begin
            @(posedge clock);
            #1;
            n++;
        end
        hangCheck(n, 6, "read answer");
        check(cpuRdData, exp, "core read");
    endtask

    task automatic doReset(input logic [7:0] b, lo, hi, s, input logic [1:0] env);
        int n;
        bootByte = b;
        codeLo = lo;
        codeHi = hi;
        secByte = s;
        envSelPins <= env;
        testMode <= 1'b0;
        rstn <= 1'b0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        regRd <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            regAddr <= OFS[i];
            @(posedge clock);
            #1;
            check(regRdata, PRE[i], "value before load");
        end
        regRd <= 1'b0;
        n = 0;
        while (loadDone !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        hangCheck(n, 20, "load done");
        checkRegs(b, lo, hi, s);
    endtask

    initial begin
        {rstn, regWr, regRd, testMode, securityOverridePin, cpuRdReq} = '0;
        {regAddr, regWdata, cpuRdAddr, envSelPins} = '0;
        cpuReq = '0;
        testReq = '0;
        errTotal = 0;
        samplesChecked = 0;
        doReset(8'h81, 8'h30, 8'h1C, 8'h33, 2'b11);
        check({14'h0000, inSystemProgEnv, normalRunEnv}, 16'h0001, "environment");
        foreach (ROWS[i])
            sendReq(1'b0, ROWS[i].op, ROWS[i].addr, ROWS[i].key, ROWS[i].ok);
        $display("Test region table finished at %0t", $time);
        regWrite(`FPP_OFS_KEY, 16'h006A);
        sendReq(1'b0, WR, 16'hE012, 1'b1, 1'b1);
        regWrite(`FPP_OFS_KEY, 16'h006A);
        regWrite(`FPP_OFS_KEY, 16'h0055);
        sendReq(1'b0, WR, 16'hE012, 1'b0, 1'b0);
        regWrite(`FPP_OFS_KEY, 16'h006A);
        regWrite(`FPP_OFS_BOOT, 16'h0000);
        sendReq(1'b0, WR, 16'hE012, 1'b0, 1'b0);
        regWrite(`FPP_OFS_KEY, 16'h006A);
        sendReq(1'b0, WR, 16'h2000, 1'b0, 1'b1);
        sendReq(1'b0, WR, 16'hE012, 1'b0, 1'b0);
        regRead(`FPP_OFS_KEY, 16'h00FF, "key read");
        regRead(8'h10, 16'h0000, "unmapped read");
        bootByte = 8'h00;
        secByte = 8'h00;
        checkRegs(8'h81, 8'h30, 8'h1C, 8'h33);
        cpuRead(16'h0100, memWord(16'h0100));
        $display("Test key and registers finished at %0t", $time);
        doReset(8'h7F, 8'hFF, 8'h63, 8'h00, 2'b11);
        check({14'h0000, inSystemProgEnv, normalRunEnv}, 16'h0002, "environment");
        cpuRead(16'h0100, 16'h0000);
        sendReq(1'b0, WR, 16'h2000, 1'b0, 1'b0);
        sendReq(1'b0, MS, 16'h0000, 1'b1, 1'b0);
        sendReq(1'b0, ER, 16'hE5FB, 1'b1, 1'b0);
        securityOverridePin <= 1'b1;
        sendReq(1'b0, WR, 16'h2000, 1'b0, 1'b1);
        securityOverridePin <= 1'b0;
        $display("Test locks finished at %0t", $time);
        doReset(8'h7F, 8'hFF, 8'hA3, 8'h31, 2'b01);
        check({14'h0000, inSystemProgEnv, normalRunEnv}, 16'h0001, "environment");
        cpuRead(16'h0100, memWord(16'h0100));
        sendReq(1'b0, WR, 16'h0000, 1'b0, 1'b1);
        sendReq(1'b0, WR, 16'h1FFF, 1'b0, 1'b1);
        sendReq(1'b0, ER, 16'hE5FB, 1'b1, 1'b0);
        testMode <= 1'b1;
        @(posedge clock);
        #1;
        sendReq(1'b1, WR, 16'hE010, 1'b0, 1'b1);
        sendReq(1'b1, ER, 16'hE5FA, 1'b0, 1'b1);
        sendReq(1'b1, ER, 16'hE5FB, 1'b0, 1'b0);
        $display("Test pin access finished at %0t", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
